// ### src/clpmc_regs.vh
`ifndef CLPMC_REGS_VH
`define CLPMC_REGS_VH
// register byte offsets
`define CLPMC_OFF_CTRL0 8'h00
`define CLPMC_OFF_CTRL1 8'h04
`define CLPMC_OFF_STATUS 8'h08
// control_reg0 fields
`define CLPMC_C0_INIT_REQ 0
`define CLPMC_C0_SLEEP_REQ 1
`define CLPMC_C0_WAKE_EN 2
// control_reg1 fields
`define CLPMC_C1_MOD_EN 0
`define CLPMC_C1_WAIT_PD 1
`define CLPMC_C1_FILT_SEL 2
`define CLPMC_C1_WAKE_IRQ_EN 3
// status fields
`define CLPMC_ST_INIT_ACK 0
`define CLPMC_ST_SLEEP_ACK 1
`define CLPMC_ST_WAKE_FLAG 2
`define CLPMC_ST_PDOWN 3
`define CLPMC_ST_MODE_LSB 4
`define CLPMC_ST_MODE_MSB 7
// reset values
`define CLPMC_RST_CTRL0 3'h1
`define CLPMC_RST_CTRL1 4'h0
// timing
`define CLPMC_CLK_NS 50
`define CLPMC_SYNC_NS 100
`define CLPMC_SYNC_CYC ((`CLPMC_SYNC_NS + `CLPMC_CLK_NS - 1) / `CLPMC_CLK_NS)
`define CLPMC_INIT_SYNC_NS 250
`define CLPMC_INIT_SYNC_CYC ((`CLPMC_INIT_SYNC_NS + `CLPMC_CLK_NS - 1) / `CLPMC_CLK_NS)
`define CLPMC_RECOV_NS 800
`define CLPMC_RECOV_CYC ((`CLPMC_RECOV_NS + `CLPMC_CLK_NS - 1) / `CLPMC_CLK_NS)
`define CLPMC_FILT_NS 2000
`define CLPMC_FILT_CYC ((`CLPMC_FILT_NS + `CLPMC_CLK_NS - 1) / `CLPMC_CLK_NS)
`define CLPMC_RESYNC_BITS 11
`define CLPMC_BIT_DIV 40
`endif

// ### src/clpmc_top.v
// Contract
// RL1: wait state with wait powerdown select enters power-down; leaving restarts to normal.
// RL2: wait state without powerdown select keeps normal operation and interrupts.
// RL3: deep stop states force power-down whatever the sleep bits hold.
// RL4: light stop follows prior sleep bits; wait select ignored in stop.
// RL5: software sets sleep request and see acknowledge before light stop.
// RL6: sleep waits until all transmit buffers report empty.
// RL7: receiving finishes first; idle controller sleeps after a fixed sync delay.
// RL8: sleep acknowledge set once sleep is active; software waits for it.
// RL9: sleep stops engine clocks, keeps register clocks, tx recessive, bus-off paused.
// RL10: sleep keeps buffers accessible, blocks foreground shift and aborts.
// RL11: without wake enable at sleep entry, receive held recessive, locked asleep.
// RL12: sleep left only on armed bus activity or software clearing request; the code also leaves it on an init request or module enable low.
// RL13: clearing sleep request ignored until sleep is active.
// RL14: after wake-up wait 11 recessive bits before joining the bus.
// RL15: wake-up releases deferred copy, aborts, transmissions and bus-off counting.
// RL16: init entry aborts transfers, drops sync, drives tx recessive.
// RL17: init stops engine, holds registers at defaults, opens config writes.
// RL18: init request synchronised with delay; init acknowledge once fully initialised.
// RL19: clearing init request ignored until init mode is active.
// RL20: power-down stops transfers, tx recessive, all clocks off, no register access.
// RL21: power-down without prior sleep runs a fixed recovery before normal.
// RL22: filter select low-pass filters receive input during sleep.
// RL23: wake-up interrupt only when asleep, wake enabled and interrupt enabled.
// RL24: module enable low stops all clocks regardless of other settings.
`timescale 1ns/100ps
`include "clpmc_regs.vh"
module clpmc_top #(
  parameter BIT_DIV = `CLPMC_BIT_DIV
)(
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // host cpu power state
  input wire cpu_wait,
  input wire cpu_stop_light,
  input wire cpu_stop_deep,
  // protocol engine status
  input wire [2:0] tx_buffer_empty_flag,
  input wire eng_receiving,
  input wire bus_idle,
  input wire eng_tx_bit,
  // bus pins
  input wire bus_rx_pin,
  output reg bus_tx_pin,
  // engine controls
  output reg eng_rx_bit,
  output reg eng_clk_en,
  output reg reg_clk_en,
  output reg eng_abort,
  output reg busoff_count_en,
  output reg deferred_en,
  output reg defaults_hold,
  output reg cfg_write_en,
  output reg wakeup_irq
);

  // mode states
  localparam ST_NORMAL = 3'h0;
  localparam ST_SLP_PEND = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_RESYNC = 3'h3;
  localparam ST_INIT_PEND = 3'h4;
  localparam ST_INIT = 3'h5;
  localparam ST_PDOWN = 3'h6;
  localparam ST_RECOVER = 3'h7;
  localparam [15:0] SYNC_CYC = `CLPMC_SYNC_CYC;
  localparam [15:0] INIT_SYNC_CYC = `CLPMC_INIT_SYNC_CYC;
  localparam [15:0] RECOV_CYC = `CLPMC_RECOV_CYC;
  localparam [15:0] FILT_CYC = `CLPMC_FILT_CYC;
  localparam [15:0] RESYNC_BITS = `CLPMC_RESYNC_BITS;
  localparam [15:0] BIT_DIV_W = BIT_DIV;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg was_sleep_ff;
  reg nxt_was_sleep;
  reg off_ff;
  reg [2:0] ctrl0_ff;
  reg [3:0] ctrl1_ff;
  reg wake_flag_ff;
  reg wake_armed_ff;
  reg [15:0] flt_cnt_ff;
  reg [15:0] div_ff;
  reg bit_tick_ff;
  reg wake_by_bus;
  wire init_request = ctrl0_ff[`CLPMC_C0_INIT_REQ];
  wire sleep_request = ctrl0_ff[`CLPMC_C0_SLEEP_REQ];
  wire wakeup_enable = ctrl0_ff[`CLPMC_C0_WAKE_EN];
  wire module_enable = ctrl1_ff[`CLPMC_C1_MOD_EN];
  wire wait_powerdown_sel = ctrl1_ff[`CLPMC_C1_WAIT_PD];
  wire wakeup_filter_sel = ctrl1_ff[`CLPMC_C1_FILT_SEL];
  wire wakeup_irq_enable = ctrl1_ff[`CLPMC_C1_WAKE_IRQ_EN];
  wire sleep_ack = (state_ff == ST_SLEEP) | ((state_ff == ST_PDOWN) & was_sleep_ff);
  wire init_ack = (state_ff == ST_INIT);
  wire any_stop = cpu_stop_light | cpu_stop_deep;
  wire apb_acc = psel & penable & pready;
  wire apb_wr = apb_acc & pwrite & ~pslverr;
  // power-down demand from the cpu state
  wire pd_cond = cpu_stop_deep // see RL3
    | (cpu_stop_light & ~(sleep_request & sleep_ack)) // see RL4
    | (cpu_wait & wait_powerdown_sel & ~any_stop); // see RL1 see RL2
  wire all_empty = &tx_buffer_empty_flag;
  // plain mode acts on one dominant sample; filter needs a sustained low
  wire wake_act = wakeup_filter_sel ? (flt_cnt_ff >= FILT_CYC) : ~bus_rx_pin; // see RL22
  // bit-rate enable for counting recessive bits
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      div_ff <= 16'h0000;
      bit_tick_ff <= 1'b0;
    end
    else if (div_ff >= BIT_DIV_W - 16'h0001)
    begin
      div_ff <= 16'h0000;
      bit_tick_ff <= 1'b1;
    end
    else
    begin
      div_ff <= div_ff + 16'h0001;
      bit_tick_ff <= 1'b0;
    end
  end
  // glitch filter on the receive line, only run while asleep
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      flt_cnt_ff <= 16'h0000;
    else if (state_ff != ST_SLEEP || bus_rx_pin)
      flt_cnt_ff <= 16'h0000;
    else if (flt_cnt_ff < FILT_CYC)
      flt_cnt_ff <= flt_cnt_ff + 16'h0001; // see RL22
  end
  // mode sequencer
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_was_sleep = was_sleep_ff;
    wake_by_bus = 1'b0;
    if (!module_enable)
    begin
      nxt_state = ST_NORMAL; // see RL24
      nxt_cnt = 16'h0000;
    end
    else if (pd_cond && state_ff != ST_PDOWN)
    begin
      nxt_state = ST_PDOWN; // see RL20
      nxt_was_sleep = (state_ff == ST_SLEEP);
      nxt_cnt = 16'h0000;
    end
    else if (init_request && state_ff != ST_INIT_PEND && state_ff != ST_INIT
             && state_ff != ST_PDOWN && state_ff != ST_RECOVER)
    begin
      nxt_state = ST_INIT_PEND; // see RL16
      nxt_cnt = 16'h0000;
    end
    else
    begin
      case (state_ff)
        ST_NORMAL:
        begin
          if (off_ff)
            nxt_state = ST_RESYNC;
          else if (sleep_request)
            nxt_state = ST_SLP_PEND;
          nxt_cnt = 16'h0000;
        end
        ST_SLP_PEND:
        begin
          // transmit and receive drain before the sync delay starts
          if (all_empty && !eng_receiving && bus_idle) // see RL6 see RL7
          begin
            if (cnt_ff >= SYNC_CYC - 16'h0001)
            begin
              nxt_state = ST_SLEEP; // see RL8
              nxt_cnt = 16'h0000;
            end
            else
              nxt_cnt = cnt_ff + 16'h0001;
          end
          else
            nxt_cnt = 16'h0000;
        end
        ST_SLEEP:
        begin
          if (!sleep_request)
            nxt_state = ST_RESYNC; // see RL12
          else if (wake_act && wake_armed_ff)
          begin
            nxt_state = ST_RESYNC; // see RL12
            wake_by_bus = 1'b1;
          end
          nxt_cnt = 16'h0000;
        end
        ST_RESYNC:
        begin
          // a dominant bit restarts the recessive run
          if (bit_tick_ff)
          begin
            if (!bus_rx_pin)
              nxt_cnt = 16'h0000;
            else if (cnt_ff >= RESYNC_BITS - 16'h0001)
            begin
              nxt_state = ST_NORMAL; // see RL14
              nxt_cnt = 16'h0000;
            end
            else
              nxt_cnt = cnt_ff + 16'h0001;
          end
        end
        ST_INIT_PEND:
        begin
          if (cnt_ff >= INIT_SYNC_CYC - 16'h0001)
          begin
            nxt_state = ST_INIT; // see RL18
            nxt_cnt = 16'h0000;
          end
          else
            nxt_cnt = cnt_ff + 16'h0001;
        end
        ST_INIT:
        begin
          if (!init_request)
            nxt_state = ST_RESYNC;
          nxt_cnt = 16'h0000;
        end
        ST_PDOWN:
        begin
          if (!pd_cond)
            nxt_state = was_sleep_ff ? ST_SLEEP : ST_RECOVER; // see RL1
          nxt_cnt = 16'h0000;
        end
        ST_RECOVER:
        begin
          if (cnt_ff >= RECOV_CYC - 16'h0001)
          begin
            nxt_state = ST_RESYNC; // see RL21
            nxt_cnt = 16'h0000;
          end
          else
            nxt_cnt = cnt_ff + 16'h0001;
        end
        default:
        begin
          nxt_state = ST_NORMAL;
          nxt_cnt = 16'h0000;
        end
      endcase
    end
  end
  // state registers
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ST_NORMAL;
      cnt_ff <= 16'h0000;
      was_sleep_ff <= 1'b0;
      off_ff <= 1'b1;
      wake_armed_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      was_sleep_ff <= nxt_was_sleep;
      off_ff <= ~module_enable;
      // wake enable only counts as it stood at sleep entry
      if (state_ff != ST_SLEEP && nxt_state == ST_SLEEP && !was_sleep_ff)
        wake_armed_ff <= wakeup_enable; // see RL11
      else if (state_ff == ST_SLP_PEND)
        wake_armed_ff <= wakeup_enable; // see RL11
    end
  end
  // software registers
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl0_ff <= `CLPMC_RST_CTRL0;
      ctrl1_ff <= `CLPMC_RST_CTRL1;
      wake_flag_ff <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == `CLPMC_OFF_CTRL0)
      begin
        // a clear is ignored until the matching mode is reached
        if (pwdata[`CLPMC_C0_INIT_REQ] || init_ack)
          ctrl0_ff[`CLPMC_C0_INIT_REQ] <= pwdata[`CLPMC_C0_INIT_REQ]; // see RL19
        if ((pwdata[`CLPMC_C0_SLEEP_REQ] || sleep_ack) && !init_ack)
          ctrl0_ff[`CLPMC_C0_SLEEP_REQ] <= pwdata[`CLPMC_C0_SLEEP_REQ]; // see RL13
        if (!init_ack)
          ctrl0_ff[`CLPMC_C0_WAKE_EN] <= pwdata[`CLPMC_C0_WAKE_EN];
      end
      else if (wake_by_bus)
        ctrl0_ff[`CLPMC_C0_SLEEP_REQ] <= 1'b0; // see RL12
      if (state_ff == ST_INIT)
      begin
        ctrl0_ff[`CLPMC_C0_SLEEP_REQ] <= 1'b0; // see RL17
        ctrl0_ff[`CLPMC_C0_WAKE_EN] <= 1'b0; // see RL17
      end
      if (apb_wr && paddr == `CLPMC_OFF_CTRL1)
        ctrl1_ff <= pwdata[3:0];
      // set beats a clear in the same cycle
      if (wake_by_bus && wakeup_irq_enable)
        wake_flag_ff <= 1'b1; // see RL23
      else if (state_ff == ST_INIT)
        wake_flag_ff <= 1'b0; // see RL17
      else if (apb_wr && paddr == `CLPMC_OFF_STATUS && pwdata[`CLPMC_ST_WAKE_FLAG])
        wake_flag_ff <= 1'b0;
    end
  end

  // apb slave: one wait state, error when unmapped or powered down
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= (state_ff == ST_PDOWN) // see RL20
        | ~((paddr == `CLPMC_OFF_CTRL0) | (paddr == `CLPMC_OFF_CTRL1)
        | (paddr == `CLPMC_OFF_STATUS));
      prdata <= 32'h00000000;
      if (state_ff != ST_PDOWN && !pwrite)
      begin
        case (paddr)
          `CLPMC_OFF_CTRL0: prdata <= {29'h00000000, ctrl0_ff};
          `CLPMC_OFF_CTRL1: prdata <= {28'h0000000, ctrl1_ff};
          `CLPMC_OFF_STATUS: prdata <= {24'h000000, 1'b0, state_ff, pd_cond,
                                        wake_flag_ff, sleep_ack, init_ack};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // engine and pin controls, registered from the next mode; wake-up interrupt registered from the wake flag
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_tx_pin <= 1'b1;
      eng_rx_bit <= 1'b1;
      eng_clk_en <= 1'b0;
      reg_clk_en <= 1'b0;
      eng_abort <= 1'b0;
      busoff_count_en <= 1'b0;
      deferred_en <= 1'b0;
      defaults_hold <= 1'b0;
      cfg_write_en <= 1'b0;
      wakeup_irq <= 1'b0;
    end
    else
    begin
      // only active modes may drive the bus; all else stays recessive
      bus_tx_pin <= ((nxt_state == ST_NORMAL || nxt_state == ST_SLP_PEND) && module_enable)
        ? eng_tx_bit : 1'b1; // see RL9 see RL16 see RL20
      eng_rx_bit <= (nxt_state == ST_SLEEP && !wake_armed_ff) ? 1'b1 : bus_rx_pin; // see RL11
      eng_clk_en <= module_enable && (nxt_state == ST_NORMAL || nxt_state == ST_SLP_PEND
        || nxt_state == ST_RESYNC); // see RL9 see RL17 see RL24
      reg_clk_en <= module_enable && nxt_state != ST_PDOWN; // see RL9 see RL20
      eng_abort <= module_enable && (nxt_state == ST_INIT_PEND || nxt_state == ST_PDOWN)
        && nxt_state != state_ff; // see RL16 see RL20
      busoff_count_en <= module_enable && (nxt_state == ST_NORMAL
        || nxt_state == ST_SLP_PEND || nxt_state == ST_RESYNC); // see RL9 see RL15
      deferred_en <= module_enable && (nxt_state == ST_NORMAL
        || nxt_state == ST_SLP_PEND || nxt_state == ST_RESYNC); // see RL10 see RL15
      defaults_hold <= module_enable && nxt_state == ST_INIT; // see RL17
      cfg_write_en <= module_enable && nxt_state == ST_INIT; // see RL17
      wakeup_irq <= wake_flag_ff && wakeup_irq_enable; // see RL23
    end
  end

endmodule // clpmc_top

// ### verif/clpmc_chk_sva.sv
`timescale 1ns/100ps
module clpmc_chk_sva (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // apb handshake
  input wire psel,
  input wire penable,
  input wire pready,
  // cpu state and pins
  input wire cpu_stop_deep,
  input wire bus_rx_pin,
  input wire bus_tx_pin,
  // engine controls
  input wire eng_rx_bit,
  input wire eng_clk_en,
  input wire reg_clk_en,
  input wire eng_abort,
  input wire busoff_count_en,
  input wire deferred_en,
  input wire defaults_hold,
  input wire cfg_write_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // setup cycle followed by the first access cycle
  sequence s_xfer;
    psel && !penable ##1 psel && penable;
  endsequence
  a_apb_one_wait: assert property (s_xfer |-> !pready ##1 pready)
    else $error("apb answer not after exactly one wait state");
  a_init_tx_idle: assert property (defaults_hold |-> bus_tx_pin)
    else $error("tx pin dominant in init mode");
  a_init_cfg_open: assert property (cfg_write_en == defaults_hold)
    else $error("config write enable differs from init hold");
  a_abort_single: assert property (eng_abort |=> !eng_abort)
    else $error("abort longer than one cycle");
  a_deep_stop_pd: assert property (
    $rose(cpu_stop_deep) && eng_clk_en |-> ##[1:3] !reg_clk_en)
    else $error("deep stop did not stop register clocks");
  a_sleep_ctrls: assert property (
    busoff_count_en == eng_clk_en && deferred_en == eng_clk_en)
    else $error("bus-off count or deferred actions run with engine stopped");
  a_clk_order: assert property (!reg_clk_en |-> !eng_clk_en)
    else $error("engine clock runs while register clocks are off");
  a_rx_follows: assert property (
    eng_clk_en |-> eng_rx_bit == $past(bus_rx_pin))
    else $error("engine receive input not following the bus");
  a_stop_tx_rec: assert property (!eng_clk_en |-> bus_tx_pin)
    else $error("tx pin dominant while engine stopped");
  a_init_eng_stop: assert property (defaults_hold |-> !eng_clk_en && reg_clk_en)
    else $error("engine runs or registers closed in init mode");
endmodule // clpmc_chk_sva

// ### verif/clpmc_bus_model.sv
`timescale 1ns/100ps
module clpmc_bus_model (
  // clock
  input wire sys_clk,
  // bus pins
  input wire bus_tx_pin,
  output wire bus_rx_pin,
  // engine view of traffic
  output reg eng_receiving,
  output reg bus_idle
);
  reg dom_ff;
  // wired-and bus, pulled recessive when nobody drives dominant
  assign bus_rx_pin = bus_tx_pin & ~dom_ff;
  // bus starts idle
  initial
  begin
    dom_ff = 1'h0;
    eng_receiving = 1'h0;
    bus_idle = 1'h1;
  end
  // dominant activity of n cycles, seen as a frame when rx is set
  task burst(input integer n, input rx);
    begin
      @(posedge sys_clk);
      dom_ff <= 1'h1;
      bus_idle <= 1'h0;
      eng_receiving <= rx;
      repeat (n) @(posedge sys_clk);
      dom_ff <= 1'h0;
      bus_idle <= 1'h1;
      eng_receiving <= 1'h0;
    end
  endtask
endmodule // clpmc_bus_model

// ### verif/tb_can_low_power_mode_control.sv
`timescale 1ns/100ps
`include "clpmc_regs.vh"
module tb_can_low_power_mode_control;
  localparam [7:0] a0 = `CLPMC_OFF_CTRL0;
  localparam [7:0] a1 = `CLPMC_OFF_CTRL1;
  localparam [7:0] ast = `CLPMC_OFF_STATUS;
  reg sys_clk, reset, psel, penable, pwrite, cpu_wait, cpu_stop_light, cpu_stop_deep, eng_tx_bit;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg [2:0] tx_buffer_empty_flag;
  reg er;
  reg [73:0] rows [0:5];
  wire [31:0] prdata;
  wire pready, pslverr, bus_rx_pin, bus_tx_pin, eng_rx_bit, eng_clk_en, reg_clk_en, eng_abort;
  wire busoff_count_en, deferred_en, defaults_hold, cfg_write_en, wakeup_irq;
  wire eng_receiving, bus_idle;
  integer n_errors, checks_done, n_abort, i;
  clpmc_top #(.BIT_DIV(4)) u_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_wait, .cpu_stop_light, .cpu_stop_deep,
    .tx_buffer_empty_flag, .eng_receiving, .bus_idle, .eng_tx_bit, .bus_rx_pin,
    .bus_tx_pin, .eng_rx_bit, .eng_clk_en, .reg_clk_en, .eng_abort, .busoff_count_en,
    .deferred_en, .defaults_hold, .cfg_write_en, .wakeup_irq);
  clpmc_bus_model u_bus (.sys_clk, .bus_tx_pin, .bus_rx_pin, .eng_receiving, .bus_idle);
  // 20 MHz clock
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // abort pulses counted for the init entry test
  always @(posedge sys_clk)
    if (eng_abort === 1'h1)
      n_abort = n_abort + 1;
  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one transfer, held until pready is seen at a rising edge
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      @(posedge sys_clk);
      // no cycle count assumed; only the watchdog ends a hung wait
      while (pready !== 1'h1)
        @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // poll status; refused reads during power-down never count as a match
  task wait_mode(input [2:0] m);
    integer k;
    begin
      k = 0;
      apb(1'h0, ast, 32'h0);
      while ((rd[6:4] !== m || er !== 1'h0) && k < 60)
      begin
        k = k + 1;
        apb(1'h0, ast, 32'h0);
      end
      chk_word({29'h0, rd[6:4]}, {29'h0, m});
    end
  endtask
  task done(input string s);
    $display("test %0s done", s);
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // watchdog, far beyond the thousand or so cycles the run needs
  initial
  begin
    #1000000;
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial
  begin
    {psel, penable, pwrite, cpu_wait, cpu_stop_light, cpu_stop_deep} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    eng_tx_bit = 1'h1;
    tx_buffer_empty_flag = 3'h7;
    n_errors = 0;
    checks_done = 0;
    n_abort = 0;
    rows[0] = {1'h0, a0, 32'h0, 29'h0, `CLPMC_RST_CTRL0, 1'h0};
    rows[1] = {1'h0, a1, 32'h0, 28'h0, `CLPMC_RST_CTRL1, 1'h0};
    rows[2] = {1'h0, 8'h0C, 32'h0, 32'h0, 1'h1};
    rows[3] = {1'h1, 8'h0C, 32'h5, 32'h0, 1'h1};
    rows[4] = {1'h1, a1, 32'h1, 32'h0, 1'h0};
    rows[5] = {1'h0, a1, 32'h0, 32'h1, 1'h0};
    reset = 1'h1;
    cyc(10);
    reset <= 1'h0;
    chk_bit(bus_tx_pin, 1'h1);
    for (i = 0; i < 6; i = i + 1)
    begin
      apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
      if (!rows[i][73])
        chk_word(rd, rows[i][32:1]);
      chk_bit(er, rows[i][0]);
    end
    wait_mode(3'h5);
    chk_bit(rd[0], 1'h1);
    chk_bit(defaults_hold & cfg_write_en & bus_tx_pin, 1'h1);
    apb(1'h1, a0, 32'h0);
    wait_mode(3'h0);
    done("bring-up");
    // clearing the request while init is still pending is ignored
    i = n_abort;
    apb(1'h1, a0, 32'h1);
    apb(1'h1, a0, 32'h0);
    apb(1'h0, a0, 32'h0);
    chk_word(rd, 32'h1);
    wait_mode(3'h5);
    chk_bit(n_abort == i + 1, 1'h1);
    apb(1'h1, a0, 32'h0);
    wait_mode(3'h0);
    done("init");
    // sleep held off by a scheduled buffer, then by reception
    tx_buffer_empty_flag <= 3'h5;
    apb(1'h1, a0, 32'h6);
    cyc(20);
    apb(1'h0, ast, 32'h0);
    chk_bit(rd[6:4] == 3'h1 && rd[1] == 1'h0, 1'h1);
    apb(1'h1, a0, 32'h4);
    apb(1'h0, a0, 32'h0);
    chk_word(rd, 32'h6);
    fork
      u_bus.burst(40, 1'h1);
      begin
        tx_buffer_empty_flag <= 3'h7;
        cyc(20);
        apb(1'h0, ast, 32'h0);
        chk_bit(rd[1], 1'h0);
      end
    join
    wait_mode(3'h2);
    chk_bit(rd[1], 1'h1);
    eng_tx_bit <= 1'h0;
    cyc(3);
    chk_bit(bus_tx_pin & reg_clk_en, 1'h1);
    chk_bit(eng_clk_en | busoff_count_en | deferred_en, 1'h0);
    eng_tx_bit <= 1'h1;
    done("sleep");
    // filtered wake-up: a glitch is ignored, long activity wakes
    apb(1'h1, a1, 32'hD);
    u_bus.burst(10, 1'h0);
    cyc(5);
    apb(1'h0, ast, 32'h0);
    chk_bit(rd[6:4] == 3'h2, 1'h1);
    fork
      u_bus.burst(80, 1'h0);
      begin
        cyc(60);
        apb(1'h0, ast, 32'h0);
        chk_bit(rd[6:4] == 3'h3 && wakeup_irq === 1'h1, 1'h1);
      end
    join
    cyc(20);
    apb(1'h0, ast, 32'h0);
    chk_bit(rd[6:4] == 3'h3, 1'h1);
    wait_mode(3'h0);
    apb(1'h0, a0, 32'h0);
    chk_word(rd, 32'h4);
    apb(1'h1, ast, 32'h4);
    cyc(2);
    chk_bit(wakeup_irq, 1'h0);
    done("wake");
    // unarmed sleep stays locked until software clears the request
    apb(1'h1, a0, 32'h2);
    wait_mode(3'h2);
    fork
      u_bus.burst(60, 1'h0);
      begin
        cyc(30);
        chk_bit(eng_rx_bit, 1'h1);
      end
    join
    apb(1'h0, ast, 32'h0);
    chk_bit(rd[6:4] == 3'h2, 1'h1);
    apb(1'h1, a0, 32'h0);
    wait_mode(3'h0);
    done("locked");
    // cpu wait with and without power-down select
    apb(1'h1, a1, 32'h1);
    cpu_wait <= 1'h1;
    cyc(10);
    chk_bit(eng_clk_en, 1'h1);
    apb(1'h1, a1, 32'h3);
    cyc(5);
    chk_bit(reg_clk_en, 1'h0);
    apb(1'h0, ast, 32'h0);
    chk_bit(er, 1'h1);
    cpu_wait <= 1'h0;
    cyc(3);
    apb(1'h0, ast, 32'h0);
    chk_bit(rd[6:4] == 3'h7, 1'h1);
    wait_mode(3'h0);
    cpu_stop_deep <= 1'h1;
    cyc(5);
    chk_bit(reg_clk_en, 1'h0);
    cpu_stop_deep <= 1'h0;
    wait_mode(3'h0);
    done("wait");
    // light stop from sleep keeps sleep, deep stop overrides it
    apb(1'h1, a0, 32'h2);
    wait_mode(3'h2);
    // wait with power-down select must not matter in stop
    cpu_stop_light <= 1'h1;
    cpu_wait <= 1'h1;
    cyc(10);
    chk_bit(reg_clk_en, 1'h1);
    cpu_stop_deep <= 1'h1;
    cyc(10);
    chk_bit(reg_clk_en, 1'h0);
    cpu_stop_deep <= 1'h0;
    cpu_stop_light <= 1'h0;
    cpu_wait <= 1'h0;
    wait_mode(3'h2);
    apb(1'h1, a0, 32'h0);
    wait_mode(3'h0);
    // light stop without sleep falls to power-down, then recovers
    cpu_stop_light <= 1'h1;
    cyc(5);
    chk_bit(reg_clk_en, 1'h0);
    cpu_stop_light <= 1'h0;
    wait_mode(3'h0);
    apb(1'h1, a1, 32'h0);
    cyc(5);
    chk_bit(eng_clk_en | reg_clk_en, 1'h0);
    done("stop");
    // mid-run reset brings pins, clocks and registers back to idle
    apb(1'h1, a1, 32'h1);
    @(posedge sys_clk);
    reset <= 1'h1;
    cyc(2);
    chk_bit(bus_tx_pin & eng_rx_bit, 1'h1);
    chk_bit(eng_clk_en | reg_clk_en | wakeup_irq | pready, 1'h0);
    reset <= 1'h0;
    apb(1'h0, a0, 32'h0);
    chk_word(rd, {29'h0, `CLPMC_RST_CTRL0});
    apb(1'h0, a1, 32'h0);
    chk_word(rd, {28'h0, `CLPMC_RST_CTRL1});
    done("reset");
    give_verdict;
  end
endmodule // tb_can_low_power_mode_control
bind clpmc_top clpmc_chk_sva u_chk (.sys_clk, .reset, .psel, .penable, .pready,
  .cpu_stop_deep, .bus_rx_pin, .bus_tx_pin, .eng_rx_bit, .eng_clk_en, .reg_clk_en,
  .eng_abort, .busoff_count_en, .deferred_en, .defaults_hold, .cfg_write_en);
